/* inc/sine_gen_consts.vh */
// Register map, field positions, reset values and sizes of the sine pattern generator.
`ifndef SINE_GEN_CONSTS_VH
`define SINE_GEN_CONSTS_VH
`define ADDR_W            12
`define OFS_CONTROL       12'h000
`define OFS_STEP_DIV      12'h004
`define OFS_HALF_LEN      12'h008
`define OFS_STATUS        12'h00C
`define OFS_PATTERN_BASE  12'h100
`define OFS_PATTERN_LAST  12'h1FC
`define BIT_SINE_ENABLE   7
`define BIT_RSVD_HI       6
`define BIT_RSVD_LO       5
`define BIT_BIAS_ENABLE   4
`define BIT_STAT_RUN      8
`define RST_CONTROL       8'h00
`define RST_STEP_DIV      6'h00
`define RST_HALF_LEN      5'h00
`define PATTERN_DEPTH     32
`define SAMPLE_W          9
`define DAC_W             10
`define FIFO_DEPTH        8
`define FIFO_AW           3
`define REG_CONTROL       3'h0
`define REG_STEP_DIV      3'h1
`define REG_HALF_LEN      3'h2
`define REG_STATUS        3'h3
`define REG_PATTERN       3'h4
`define REG_NONE          3'h7
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`define RESP_DECERR       2'h3
`endif

/* src/sample_fifo.v */
// Small flip-flop FIFO carrying DAC words from the sequencer to the converter.
`timescale 1ns/100ps
module sample_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             aclk,
   input  wire             aresetn,
   input  wire             ce,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wptr;
   reg [AW-1:0]    rptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;

   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data  = mem[rptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointers wrap naturally because the depth is a power of two.
   always @(posedge aclk) begin
      if (!aresetn) begin
         wptr  <= {AW{1'b0}};
         rptr  <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else if (ce) begin
         if (push) begin
            mem[wptr] <= in_data;
            wptr      <= wptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rptr <= rptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push & ~pop) begin
            count <= count + {{AW{1'b0}}, 1'b1};
         end else if (pop & ~push) begin
            count <= count - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule

/* src/sine_pattern_generator.v */
// Sine pattern sequencer with pattern store and AXI4-Lite register slave.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "sine_gen_consts.vh"
module sine_pattern_generator (
   input  wire                aclk,
   input  wire                aresetn,
   input  wire                ce,
   input  wire [`ADDR_W-1:0]  s_axi_awaddr,
   input  wire [2:0]          s_axi_awprot,
   input  wire                s_axi_awvalid,
   output wire                s_axi_awready,
   input  wire [31:0]         s_axi_wdata,
   input  wire [3:0]          s_axi_wstrb,
   input  wire                s_axi_wvalid,
   output wire                s_axi_wready,
   output reg  [1:0]          s_axi_bresp,
   output reg                 s_axi_bvalid,
   input  wire                s_axi_bready,
   input  wire [`ADDR_W-1:0]  s_axi_araddr,
   input  wire [2:0]          s_axi_arprot,
   input  wire                s_axi_arvalid,
   output wire                s_axi_arready,
   output reg  [31:0]         s_axi_rdata,
   output reg  [1:0]          s_axi_rresp,
   output reg                 s_axi_rvalid,
   input  wire                s_axi_rready,
   output wire [`DAC_W-1:0]   dac_data,
   output wire                dac_valid,
   input  wire                dac_ready,
   output reg                 dac_power_down,
   output reg                 amp_power_down,
   output reg                 bias_power_down
);
   reg  [7:0]              sine_gen_control;
   reg  [5:0]              sine_step_divisor;
   reg  [4:0]              half_pattern_length;
   reg  [`SAMPLE_W-1:0]    pattern [0:`PATTERN_DEPTH-1];
   reg                     aw_held;
   reg  [`ADDR_W-1:0]      aw_addr;
   reg                     w_held;
   reg  [31:0]             w_data;
   reg  [3:0]              w_strb;
   reg  [5:0]              div_count;
   reg  [5:0]              step_counter;
   reg  [4:0]              pattern_index;
   reg                     running;
   reg  [31:0]             next_rdata;
   reg  [1:0]              next_rresp;
   reg  [1:0]              next_bresp;
   wire                    sine_enable;
   wire                    bias_resistor_enable;
   wire [5:0]              half_pattern_steps;
   wire [6:0]              pattern_steps_per_cycle;
   wire                    step_due;
   wire                    last_step;
   wire                    upper_half;
   wire                    fifo_in_ready;
   wire                    push;
   wire [`DAC_W-1:0]       dac_word;
   wire                    dac_msb;
   wire [2:0]              wr_region;
   wire [2:0]              rd_region;
   wire [4:0]              wr_slot;
   wire [4:0]              rd_slot;

   // Decodes a byte address into a register region.
   function [2:0] region;
      input [`ADDR_W-1:0] addr;
      begin
         if (addr[1:0] != 2'h0) begin
            region = `REG_NONE;
         end else if (addr == `OFS_CONTROL) begin
            region = `REG_CONTROL;
         end else if (addr == `OFS_STEP_DIV) begin
            region = `REG_STEP_DIV;
         end else if (addr == `OFS_HALF_LEN) begin
            region = `REG_HALF_LEN;
         end else if (addr == `OFS_STATUS) begin
            region = `REG_STATUS;
         end else if (addr >= `OFS_PATTERN_BASE &&
                      addr <= `OFS_PATTERN_LAST) begin
            region = `REG_PATTERN;
         end else begin
            region = `REG_NONE;
         end
      end
   endfunction

   // Pattern byte n sits in word n of the window; byte n/2 is the sample.
   function [4:0] sample_slot;
      input [`ADDR_W-1:0] addr;
      begin
         sample_slot = addr[7:3];
      end
   endfunction

   // Odd pattern bytes carry sample bit 8 alone.
   function odd_byte;
      input [`ADDR_W-1:0] addr;
      begin
         odd_byte = addr[2];
      end
   endfunction

   assign sine_enable          = sine_gen_control[`BIT_SINE_ENABLE];
   assign bias_resistor_enable = sine_gen_control[`BIT_BIAS_ENABLE];
   assign wr_region            = region(aw_addr);
   assign rd_region            = region(s_axi_araddr);
   assign wr_slot              = sample_slot(aw_addr);
   assign rd_slot              = sample_slot(s_axi_araddr);

   // Field values are stored minus one, so add one back here.
   assign half_pattern_steps      = {1'b0, half_pattern_length} + 6'h01;
   assign pattern_steps_per_cycle = {half_pattern_steps, 1'b0};
   assign step_due   = running & (div_count == sine_step_divisor);
   assign push       = step_due & fifo_in_ready;
   assign last_step  = ({1'b0, step_counter} ==
                        (pattern_steps_per_cycle - 7'h01));
   assign upper_half = (step_counter >= half_pattern_steps);
   // The phase flag is high in the second half and is inverted on its way
   // to the converter, so the converter sees bit 9 high in the first half.
   assign dac_msb    = ~upper_half;
   assign dac_word   = {dac_msb, pattern[pattern_index]};

   // Address and data wait in their own holding flops, so either may lead.
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   // Read data and response for the address on the read channel.
   always @* begin
      next_rdata = 32'h00000000;
      next_rresp = `RESP_OKAY;
      case (rd_region)
         `REG_CONTROL: begin
            next_rdata[7:0] = sine_gen_control;
         end
         `REG_STEP_DIV: begin
            next_rdata[5:0] = sine_step_divisor;
         end
         `REG_HALF_LEN: begin
            next_rdata[4:0] = half_pattern_length;
         end
         `REG_STATUS: begin
            next_rdata[5:0]          = step_counter;
            next_rdata[`BIT_STAT_RUN] = running;
         end
         `REG_PATTERN: begin
            // A blocked access reads as zero with an error response.
            if (sine_enable) begin
               next_rresp = `RESP_SLVERR;
            end else if (odd_byte(s_axi_araddr)) begin
               next_rdata[0] = pattern[rd_slot][8];
            end else begin
               next_rdata[7:0] = pattern[rd_slot][7:0];
            end
         end
         default: begin
            next_rresp = `RESP_DECERR;
         end
      endcase
   end

   // Response for the held write.
   always @* begin
      next_bresp = `RESP_OKAY;
      case (wr_region)
         `REG_CONTROL, `REG_STEP_DIV, `REG_HALF_LEN, `REG_STATUS: begin
            next_bresp = `RESP_OKAY;
         end
         `REG_PATTERN: begin
            if (sine_enable) begin
               next_bresp = `RESP_SLVERR;
            end
         end
         default: begin
            next_bresp = `RESP_DECERR;
         end
      endcase
   end

   // Write channel: address and data are taken in either order, then applied.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held             <= 1'b0;
         aw_addr             <= {`ADDR_W{1'b0}};
         w_held              <= 1'b0;
         w_data              <= 32'h00000000;
         w_strb              <= 4'h0;
         s_axi_bvalid        <= 1'b0;
         s_axi_bresp         <= `RESP_OKAY;
         sine_gen_control    <= `RST_CONTROL;
         sine_step_divisor   <= `RST_STEP_DIV;
         half_pattern_length <= `RST_HALF_LEN;
      end else if (ce) begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (aw_held & w_held & ~s_axi_bvalid) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= next_bresp;
            // Only lane 0 carries data; a write without it changes nothing.
            if (w_strb[0]) begin
               case (wr_region)
                  `REG_CONTROL: begin
                     // Reserved bits are kept as written; software keeps them
                     // at zero.
                     sine_gen_control <= {w_data[7:4], 4'h0};
                  end
                  `REG_STEP_DIV: begin
                     sine_step_divisor <= w_data[5:0];
                  end
                  `REG_HALF_LEN: begin
                     half_pattern_length <= w_data[4:0];
                  end
                  `REG_PATTERN: begin
                     if (!sine_enable) begin
                        if (odd_byte(aw_addr)) begin
                           pattern[wr_slot][8] <= w_data[0];
                        end else begin
                           pattern[wr_slot][7:0] <= w_data[7:0];
                        end
                     end
                  end
                  default: begin
                     sine_gen_control <= sine_gen_control;
                  end
               endcase
            end
         end
      end
   end

   // Read channel: one outstanding read, answered the cycle after it is taken.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Sequencer. A full FIFO stalls the divider, so a consumer that keeps up
   // sees exact timing while a slow one never loses a sample.
   always @(posedge aclk) begin
      if (!aresetn) begin
         running       <= 1'b0;
         div_count     <= 6'h00;
         step_counter  <= 6'h00;
         pattern_index <= 5'h00;
      end else if (ce) begin
         // Counters restart from zero whenever the generator is enabled.
         running <= sine_enable;
         if (!sine_enable) begin
            div_count     <= 6'h00;
            step_counter  <= 6'h00;
            pattern_index <= 5'h00;
         end else if (running) begin
            if (push) begin
               div_count <= 6'h00;
               if (last_step) begin
                  step_counter <= 6'h00;
               end else begin
                  step_counter <= step_counter + 6'h01;
               end
               if (pattern_index == half_pattern_length) begin
                  pattern_index <= 5'h00;
               end else begin
                  pattern_index <= pattern_index + 5'h01;
               end
            end else if (!step_due) begin
               div_count <= div_count + 6'h01;
            end
         end
      end
   end

   // Analog power controls follow the control register.
   // They are registered, so no decode glitch reaches the analog side.
   always @(posedge aclk) begin
      if (!aresetn) begin
         dac_power_down  <= 1'b1;
         amp_power_down  <= 1'b1;
         bias_power_down <= 1'b1;
      end else if (ce) begin
         dac_power_down  <= ~sine_enable;
         amp_power_down  <= ~sine_enable;
         bias_power_down <= ~bias_resistor_enable;
      end
   end

   sample_fifo #(
      .WIDTH (`DAC_W),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .in_data   (dac_word),
      .in_valid  (step_due),
      .in_ready  (fifo_in_ready),
      .out_data  (dac_data),
      .out_valid (dac_valid),
      .out_ready (dac_ready)
   );
endmodule

/* sim/sine_gen_properties.sv */
// Assertions on the register bus and converter side of the sine generator.
`timescale 1ns/100ps
`include "sine_gen_consts.vh"
module sine_gen_checker (
   input wire              aclk,
   input wire              aresetn,
   input wire              s_axi_awvalid,
   input wire              s_axi_awready,
   input wire              s_axi_wvalid,
   input wire              s_axi_wready,
   input wire [1:0]        s_axi_bresp,
   input wire              s_axi_bvalid,
   input wire              s_axi_bready,
   input wire              s_axi_arvalid,
   input wire              s_axi_arready,
   input wire [31:0]       s_axi_rdata,
   input wire [1:0]        s_axi_rresp,
   input wire              s_axi_rvalid,
   input wire              s_axi_rready,
   input wire [`DAC_W-1:0] dac_data,
   input wire              dac_valid,
   input wire              dac_ready,
   input wire              dac_power_down,
   input wire              amp_power_down,
   input wire              bias_power_down
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence write_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence read_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (write_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_write_blocked: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("write taken early");
   a_read_answer: assert property (read_taken |=> s_axi_rvalid)
      else $error("read data missing");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata}))
      else $error("read data dropped");
   a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken early");
   a_power_pair: assert property (dac_power_down == amp_power_down)
      else $error("converter and amplifier power differ");
   a_word_holds: assert property (dac_valid && !dac_ready |=>
      dac_valid && $stable(dac_data)) else $error("word changed");
   a_reset_idle: assert property ($rose(aresetn) |->
      !s_axi_bvalid && !s_axi_rvalid && !dac_valid && dac_power_down &&
      bias_power_down) else $error("outputs not idle after reset");
endmodule

/* sim/dac_sink.sv */
// Behavioural converter input that takes words with optional stalls.
`timescale 1ns/100ps
module dac_sink (
   input wire       aclk,
   input wire       aresetn,
   input wire [1:0] mode,
   input wire       dac_power_down,
   output reg       dac_ready
);
   reg [7:0] lfsr;
   // Mode 0 takes every word, 1 stalls at random, 2 refuses all.
   always @(posedge aclk) begin
      if (!aresetn) begin
         lfsr <= 8'hA5;
         dac_ready <= 1'b0;
      end else begin
         lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         // A powered-down converter takes nothing.
         dac_ready <= !dac_power_down && mode != 2'h2 &&
                      (mode == 2'h0 || lfsr[0]);
      end
   end
endmodule

/* sim/test_sine_pattern_generator.sv */
// Self-checking bench for the sine pattern generator.
`timescale 1ns/100ps
`include "sine_gen_consts.vh"
module test_sine_pattern_generator;
   reg                aclk = 1'b0;
   reg                aresetn = 1'b0;
   reg                ce = 1'b1;
   reg  [2:0]         s_axi_awprot = 3'h0;
   reg  [2:0]         s_axi_arprot = 3'h0;
   reg  [`ADDR_W-1:0] s_axi_awaddr = 12'h000;
   reg  [`ADDR_W-1:0] s_axi_araddr = 12'h000;
   reg  [31:0]        s_axi_wdata = 32'h0;
   reg  [3:0]         s_axi_wstrb = 4'h0;
   reg                s_axi_awvalid = 1'b0;
   reg                s_axi_wvalid = 1'b0;
   reg                s_axi_bready = 1'b0;
   reg                s_axi_arvalid = 1'b0;
   reg                s_axi_rready = 1'b0;
   reg  [1:0]         mode = 2'h2;
   wire               s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire               s_axi_arready, s_axi_rvalid, dac_valid, dac_ready;
   wire [1:0]         s_axi_bresp, s_axi_rresp;
   wire [31:0]        s_axi_rdata;
   wire [`DAC_W-1:0]  dac_data;
   wire               dac_power_down, amp_power_down, bias_power_down;
   reg  [31:0]        seed = 32'h817590FC;
   reg  [33:0]        rq[$];
   reg  [33:0]        dq[$];
   reg  [8:0]         s[0:2];
   reg  [31:0]        lo, hi;
   reg  [11:0]        k;
   integer            bad_count = 0, checks = 0, i, j;

   sine_pattern_generator dut (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .ce              (ce),
      .s_axi_awaddr    (s_axi_awaddr),
      .s_axi_awprot    (s_axi_awprot),
      .s_axi_awvalid   (s_axi_awvalid),
      .s_axi_awready   (s_axi_awready),
      .s_axi_wdata     (s_axi_wdata),
      .s_axi_wstrb     (s_axi_wstrb),
      .s_axi_wvalid    (s_axi_wvalid),
      .s_axi_wready    (s_axi_wready),
      .s_axi_bresp     (s_axi_bresp),
      .s_axi_bvalid    (s_axi_bvalid),
      .s_axi_bready    (s_axi_bready),
      .s_axi_araddr    (s_axi_araddr),
      .s_axi_arprot    (s_axi_arprot),
      .s_axi_arvalid   (s_axi_arvalid),
      .s_axi_arready   (s_axi_arready),
      .s_axi_rdata     (s_axi_rdata),
      .s_axi_rresp     (s_axi_rresp),
      .s_axi_rvalid    (s_axi_rvalid),
      .s_axi_rready    (s_axi_rready),
      .dac_data        (dac_data),
      .dac_valid       (dac_valid),
      .dac_ready       (dac_ready),
      .dac_power_down  (dac_power_down),
      .amp_power_down  (amp_power_down),
      .bias_power_down (bias_power_down)
   );
   dac_sink sink (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .mode           (mode),
      .dac_power_down (dac_power_down),
      .dac_ready      (dac_ready)
   );
   always #4 aclk = ~aclk;

   function automatic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task end_of_test;
      if (bad_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task give_up;
      bad_count = bad_count + 1;
      end_of_test;
   endtask
   task cmp(input string nm, input [33:0] e, input [33:0] g);
      checks = checks + 1;
      if (e !== g) begin
         bad_count = bad_count + 1;
         $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
   endtask
   // Ready is raised only after valid shows, so the hold paths get used.
   task xfer(input w, input [11:0] a, input [31:0] d, input [3:0] st,
             input [33:0] e);
      reg got;
      begin
         got = 1'b0;
         rq.push_back(e);
         if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= st;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
         end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
         end
         for (i = 0; i < 40 && !got; i = i + 1) begin
            @(posedge aclk);
            if (s_axi_awready)
               s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
               s_axi_wvalid <= 1'b0;
            if (s_axi_arready)
               s_axi_arvalid <= 1'b0;
            got = (s_axi_bvalid && s_axi_bready) ||
                  (s_axi_rvalid && s_axi_rready);
            s_axi_bready <= s_axi_bvalid && !got;
            s_axi_rready <= s_axi_rvalid && !got;
         end
         if (!got)
            give_up;
         @(posedge aclk);
      end
   endtask
   task wr(input [11:0] a, input [31:0] d, input [3:0] st, input [1:0] r);
      xfer(1'b1, a, d, st, {r, 32'h0});
   endtask
   task rd(input [11:0] a, input [1:0] r, input [31:0] e);
      xfer(1'b0, a, 32'h0, 4'h0, {r, e});
   endtask
   task power_is(input [2:0] e);
      repeat (2) @(posedge aclk);
      cmp("power", {31'h0, e}, {31'h0, dac_power_down, amp_power_down,
          bias_power_down});
   endtask

   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready)
         cmp("bresp", rq.pop_front(), {s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready)
         cmp("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (dac_valid && dac_ready && dq.size() > 0)
         cmp("dac", dq.pop_front(), {24'h0, dac_data});
   end

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`OFS_CONTROL, `RESP_OKAY, 32'h0);
      rd(`OFS_STEP_DIV, `RESP_OKAY, 32'h0);
      rd(`OFS_HALF_LEN, `RESP_OKAY, 32'h0);
      power_is(3'h7);
      wr(12'h010, rnd(), 4'hF, `RESP_DECERR);
      rd(12'h014, `RESP_DECERR, 32'h0);
      // Four clocks per step and six steps per cycle: a 24-clock cycle.
      wr(`OFS_STEP_DIV, 32'h43, 4'hF, `RESP_OKAY);
      rd(`OFS_STEP_DIV, `RESP_OKAY, 32'h3);
      wr(`OFS_HALF_LEN, 32'hE2, 4'hF, `RESP_OKAY);
      rd(`OFS_HALF_LEN, `RESP_OKAY, 32'h2);
      for (k = 12'h000; k < 12'h003; k = k + 12'h001) begin
         lo = rnd();
         hi = rnd();
         s[k] = {hi[0], lo[7:0]};
         wr(`OFS_PATTERN_BASE + (k << 3), lo, 4'hF, `RESP_OKAY);
         wr(`OFS_PATTERN_BASE + (k << 3) + 12'h004, hi, 4'hF, `RESP_OKAY);
      end
      wr(`OFS_PATTERN_BASE, rnd(), 4'h0, `RESP_OKAY);
      rd(`OFS_PATTERN_BASE, `RESP_OKAY, {24'h0, s[0][7:0]});
      rd(`OFS_PATTERN_BASE + 12'h014, `RESP_OKAY, {31'h0, s[2][8]});
      for (j = 0; j < 16; j = j + 1)
         dq.push_back({24'h0, j % 6 < 3, s[j % 3]});
      wr(`OFS_CONTROL, 32'h9F, 4'hF, `RESP_OKAY);
      rd(`OFS_CONTROL, `RESP_OKAY, 32'h90);
      power_is(3'h0);
      wr(`OFS_PATTERN_BASE, rnd(), 4'hF, `RESP_SLVERR);
      rd(`OFS_PATTERN_BASE + 12'h004, `RESP_SLVERR, 32'h0);
      // The stalled sink lets the queue fill so the divider must wait.
      repeat (40) @(posedge aclk);
      rd(`OFS_STATUS, `RESP_OKAY, 32'h102);
      mode <= 2'h1;
      for (i = 0; i < 400 && dq.size() > 0; i = i + 1)
         @(posedge aclk);
      if (dq.size() > 0)
         give_up;
      wr(`OFS_CONTROL, 32'h0, 4'hF, `RESP_OKAY);
      power_is(3'h7);
      rd(`OFS_PATTERN_BASE + 12'h004, `RESP_OKAY, {31'h0, s[0][8]});
      end_of_test;
   end
endmodule
bind sine_pattern_generator sine_gen_checker checker_i (
   .aclk            (aclk),
   .aresetn         (aresetn),
   .s_axi_awvalid   (s_axi_awvalid),
   .s_axi_awready   (s_axi_awready),
   .s_axi_wvalid    (s_axi_wvalid),
   .s_axi_wready    (s_axi_wready),
   .s_axi_bresp     (s_axi_bresp),
   .s_axi_bvalid    (s_axi_bvalid),
   .s_axi_bready    (s_axi_bready),
   .s_axi_arvalid   (s_axi_arvalid),
   .s_axi_arready   (s_axi_arready),
   .s_axi_rdata     (s_axi_rdata),
   .s_axi_rresp     (s_axi_rresp),
   .s_axi_rvalid    (s_axi_rvalid),
   .s_axi_rready    (s_axi_rready),
   .dac_data        (dac_data),
   .dac_valid       (dac_valid),
   .dac_ready       (dac_ready),
   .dac_power_down  (dac_power_down),
   .amp_power_down  (amp_power_down),
   .bias_power_down (bias_power_down)
);
